/* File: rtl/cif_ack_select.sv */
// Forms the acknowledge value of one group: real ID or a special ID.
// Assumes pending inputs come from the prioritiser on the same clock.
`timescale 1ns/1ps
module cif_ack_select #(
  parameter bit ALLOW_WHY = 1'b1
) (
  input  wire logic        pend_valid,
  input  wire logic [23:0] pend_id,
  input  wire logic        prio_ok,
  input  wire logic        ack_ok,
  input  wire logic        enable,
  input  wire logic        held,
  input  wire logic        id_width_24,
  input  wire logic [1:0]  why,
  output logic             present,
  output logic             real_id,
  output logic [23:0]      ack_id
);

  logic [23:0] spec_id;

  assign present = pend_valid && prio_ok && enable && !held;
  assign real_id = present && ack_ok;

  always_comb
  begin
    spec_id = cif_pkg::ID_SPEC_1023;
    if (ALLOW_WHY)
    begin
      case (why)
        cif_pkg::CIF_WHY_SEC:  spec_id = cif_pkg::ID_SPEC_1020;
        cif_pkg::CIF_WHY_NSEC: spec_id = cif_pkg::ID_SPEC_1021;
        default:               spec_id = cif_pkg::ID_SPEC_1023;
      endcase
    end
  end

  always_comb
  begin
    ack_id = real_id ? pend_id : spec_id;
    if (!id_width_24)
      ack_id[23:16] = 8'h00;
  end

endmodule : cif_ack_select

/* File: rtl/cif_ack_top.sv */
// CPU interface acknowledge registers, group 0 enable and access checks.
// Assumes the core presents one system register access per request pulse
// on this clock, and takes the answer on the following cycle.
`timescale 1ns/1ps
module cif_ack_top (
  input  wire logic        clock,
  input  wire logic        rst_b,
  // Access request from the core
  input  wire logic        req_valid,
  input  wire logic        req_write,
  input  wire logic [1:0]  req_el,
  input  wire logic        req_monitor_mode,
  input  wire logic [3:0]  req_coproc,
  input  wire logic [2:0]  req_opc1,
  input  wire logic [3:0]  req_crn,
  input  wire logic [3:0]  req_crm,
  input  wire logic [2:0]  req_opc2,
  input  wire logic [31:0] req_wdata,
  // Answer to the core
  output logic             rsp_valid,
  output logic [1:0]       rsp_status,
  output logic [5:0]       rsp_syndrome,
  output logic [31:0]      rsp_rdata,
  // Control bits held elsewhere in the core
  input  wire logic        hyp_enabled,
  input  wire logic        monitor_present,
  input  wire logic        hyp_cp15_trap_bit,
  input  wire logic        os_sysreg_enable,
  input  wire logic        hyp_sysreg_enable,
  input  wire logic        monitor_sysreg_enable,
  input  wire logic        trap_all_group0,
  input  wire logic        trap_all_group1,
  input  wire logic        hyp_fiq_route,
  input  wire logic        hyp_irq_route,
  input  wire logic        monitor_fiq_route,
  input  wire logic        monitor_irq_route,
  input  wire logic        id_width_24,
  input  wire logic        group1_enable,
  // Top pending interrupts from the prioritiser
  input  wire logic        g0_pend_valid,
  input  wire logic [23:0] g0_pend_id,
  input  wire logic        g0_pend_prio_ok,
  input  wire logic        g0_pend_ack_ok,
  input  wire logic [1:0]  g0_why,
  input  wire logic        g1_pend_valid,
  input  wire logic [23:0] g1_pend_id,
  input  wire logic        g1_pend_prio_ok,
  input  wire logic        g1_pend_ack_ok,
  input  wire logic        vg0_pend_valid,
  input  wire logic [23:0] vg0_pend_id,
  input  wire logic        vg1_pend_valid,
  input  wire logic [23:0] vg1_pend_id,
  // State and events toward the rest of the interface
  output logic             group0_enable,
  output logic             virtual_group0_enable_bit,
  output logic             fiq_signal,
  output logic             irq_signal,
  output logic             act_valid,
  output logic             act_group,
  output logic             act_virtual,
  output logic [23:0]      act_id,
  output logic             g0_release
);

  // Encoding match for one register in the shared space
  function automatic logic enc_hit(
    input logic [3:0] coproc,
    input logic [2:0] opc1,
    input logic [3:0] crn,
    input logic [3:0] crm,
    input logic [2:0] opc2,
    input logic [3:0] want_crm,
    input logic [2:0] want_opc2
  );
    enc_hit = coproc == cif_pkg::ENC_COPROC && opc1 == cif_pkg::ENC_OPC1
              && crn == cif_pkg::ENC_CRN && crm == want_crm
              && opc2 == want_opc2;
  endfunction : enc_hit

  // Privilege walk shared by both groups; order gives precedence
  function automatic cif_pkg::cif_chk_t access_check(
    input logic [1:0] el,
    input logic       mon_mode,
    input logic       hyp_en,
    input logic       mon_en,
    input logic       t12,
    input logic       sre_os,
    input logic       sre_hyp,
    input logic       sre_mon,
    input logic       tall,
    input logic       hyp_route,
    input logic       mon_route
  );
    access_check = cif_pkg::CIF_CHK_PHYS;
    case (el)
      cif_pkg::CIF_EL0:
        access_check = cif_pkg::CIF_CHK_UNDEF;
      cif_pkg::CIF_EL1:
      begin
        if (hyp_en && t12)
          access_check = cif_pkg::CIF_CHK_THYP;
        else if (!sre_os)
          access_check = cif_pkg::CIF_CHK_UNDEF;
        else if (hyp_en && tall)
          access_check = cif_pkg::CIF_CHK_THYP;
        else if (hyp_en && hyp_route)
          access_check = cif_pkg::CIF_CHK_VIRT;
        else if (mon_en && mon_route && !mon_mode)
          access_check = cif_pkg::CIF_CHK_TMON;
        else
          access_check = cif_pkg::CIF_CHK_PHYS;
      end
      cif_pkg::CIF_EL2:
      begin
        if (!sre_hyp)
          access_check = cif_pkg::CIF_CHK_UNDEF;
        else if (mon_en && mon_route)
          access_check = cif_pkg::CIF_CHK_TMON;
        else
          access_check = cif_pkg::CIF_CHK_PHYS;
      end
      cif_pkg::CIF_EL3:
      begin
        if (!sre_mon)
          access_check = cif_pkg::CIF_CHK_UNDEF;
        else
          access_check = cif_pkg::CIF_CHK_PHYS;
      end
      default:
        access_check = cif_pkg::CIF_CHK_UNDEF;
    endcase
  endfunction : access_check

  logic              en0_ff;
  logic              ven0_ff;
  logic              rsp_valid_ff;
  logic [1:0]        rsp_status_ff;
  logic [5:0]        rsp_syndrome_ff;
  logic [31:0]       rsp_rdata_ff;
  logic              act_valid_ff;
  logic              act_group_ff;
  logic              act_virtual_ff;
  logic [23:0]       act_id_ff;
  logic              release_ff;

  logic              hit_ack0;
  logic              hit_ack1;
  logic              hit_en0;
  cif_pkg::cif_chk_t chk_g0;
  cif_pkg::cif_chk_t chk_g1;
  cif_pkg::cif_chk_t chk;
  logic              held_g0;
  logic              held_g1;
  logic              pres_g0;
  logic              pres_g1;
  logic              real_g0;
  logic              real_g1;
  logic [23:0]       id_g0;
  logic [23:0]       id_g1;
  logic [23:0]       vid_g0;
  logic [23:0]       vid_g1;
  logic              served;
  logic              do_rd;
  logic              do_wr;
  logic              act_g0;
  logic              act_g1;
  logic              vact;
  logic [1:0]        nxt_status;
  logic [31:0]       nxt_rdata;

  // Decode
  assign hit_ack0 = enc_hit(req_coproc, req_opc1, req_crn, req_crm, req_opc2,
                            cif_pkg::ENC_CRM_ACK0, cif_pkg::ENC_OPC2_ACK);
  assign hit_ack1 = enc_hit(req_coproc, req_opc1, req_crn, req_crm, req_opc2,
                            cif_pkg::ENC_CRM_ACK1, cif_pkg::ENC_OPC2_ACK);
  assign hit_en0  = enc_hit(req_coproc, req_opc1, req_crn, req_crm, req_opc2,
                            cif_pkg::ENC_CRM_EN0, cif_pkg::ENC_OPC2_EN0);

  // Group 0 registers, including the enable, follow FIQ routing
  assign chk_g0 = access_check(req_el, req_monitor_mode, hyp_enabled,
                               monitor_present, hyp_cp15_trap_bit,
                               os_sysreg_enable, hyp_sysreg_enable,
                               monitor_sysreg_enable, trap_all_group0,
                               hyp_fiq_route, monitor_fiq_route);
  assign chk_g1 = access_check(req_el, req_monitor_mode, hyp_enabled,
                               monitor_present, hyp_cp15_trap_bit,
                               os_sysreg_enable, hyp_sysreg_enable,
                               monitor_sysreg_enable, trap_all_group1,
                               hyp_irq_route, monitor_irq_route);
  assign chk    = hit_ack1 ? chk_g1 : chk_g0;

  // Acknowledge registers are read only; a write to them is undefined
  assign served = req_valid && (hit_en0 || ((hit_ack0 || hit_ack1) && !req_write))
                  && (chk == cif_pkg::CIF_CHK_PHYS || chk == cif_pkg::CIF_CHK_VIRT);
  assign do_rd  = served && !req_write;
  assign do_wr  = served && req_write;

  cif_pend_track u_track_g0 (
    .clock      (clock),
    .rst_b      (rst_b),
    .pend_valid (g0_pend_valid),
    .pend_id    (g0_pend_id),
    .activate   (act_g0),
    .held       (held_g0)
  );

  cif_pend_track u_track_g1 (
    .clock      (clock),
    .rst_b      (rst_b),
    .pend_valid (g1_pend_valid),
    .pend_id    (g1_pend_id),
    .activate   (act_g1),
    .held       (held_g1)
  );

  cif_ack_select #(
    .ALLOW_WHY (1'b1)
  ) u_sel_g0 (
    .pend_valid  (g0_pend_valid),
    .pend_id     (g0_pend_id),
    .prio_ok     (g0_pend_prio_ok),
    .ack_ok      (g0_pend_ack_ok),
    .enable      (en0_ff),
    .held        (held_g0),
    .id_width_24 (id_width_24),
    .why         (g0_why),
    .present     (pres_g0),
    .real_id     (real_g0),
    .ack_id      (id_g0)
  );

  cif_ack_select #(
    .ALLOW_WHY (1'b0)
  ) u_sel_g1 (
    .pend_valid  (g1_pend_valid),
    .pend_id     (g1_pend_id),
    .prio_ok     (g1_pend_prio_ok),
    .ack_ok      (g1_pend_ack_ok),
    .enable      (group1_enable),
    .held        (held_g1),
    .id_width_24 (id_width_24),
    .why         (2'h0),
    .present     (pres_g1),
    .real_id     (real_g1),
    .ack_id      (id_g1)
  );

  // Virtual copies: no interrupt reads as 1023
  always_comb
  begin
    vid_g0 = vg0_pend_valid ? vg0_pend_id : cif_pkg::ID_SPEC_1023;
    vid_g1 = vg1_pend_valid ? vg1_pend_id : cif_pkg::ID_SPEC_1023;
    if (!id_width_24)
    begin
      vid_g0[23:16] = 8'h00;
      vid_g1[23:16] = 8'h00;
    end
  end

  assign vact   = chk == cif_pkg::CIF_CHK_VIRT;
  assign act_g0 = do_rd && hit_ack0 && !vact && real_g0;
  assign act_g1 = do_rd && hit_ack1 && !vact && real_g1;

  always_comb
  begin
    nxt_rdata = 32'h00000000;
    if (hit_ack0)
      nxt_rdata[23:0] = vact ? vid_g0 : id_g0;
    else if (hit_ack1)
      nxt_rdata[23:0] = vact ? vid_g1 : id_g1;
    else
      nxt_rdata[cif_pkg::EN0_BIT] = vact ? ven0_ff : en0_ff;
  end

  always_comb
  begin
    nxt_status = cif_pkg::CIF_RSP_OK;
    if (!hit_en0 && !((hit_ack0 || hit_ack1) && !req_write))
      nxt_status = cif_pkg::CIF_RSP_UNDEF;
    else
    begin
      case (chk)
        cif_pkg::CIF_CHK_THYP:  nxt_status = cif_pkg::CIF_RSP_THYP;
        cif_pkg::CIF_CHK_TMON:  nxt_status = cif_pkg::CIF_RSP_TMON;
        cif_pkg::CIF_CHK_UNDEF: nxt_status = cif_pkg::CIF_RSP_UNDEF;
        default:                nxt_status = cif_pkg::CIF_RSP_OK;
      endcase
    end
  end

  // Answer one cycle after the request
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rsp_valid_ff    <= 1'b0;
      rsp_status_ff   <= cif_pkg::CIF_RSP_OK;
      rsp_syndrome_ff <= 6'h00;
      rsp_rdata_ff    <= 32'h00000000;
    end
    else
    begin
      rsp_valid_ff    <= req_valid;
      if (req_valid)
      begin
        rsp_status_ff   <= nxt_status;
        rsp_syndrome_ff <= (nxt_status == cif_pkg::CIF_RSP_THYP)
                           ? cif_pkg::SYND_CP15 : 6'h00;
        rsp_rdata_ff    <= do_rd ? nxt_rdata : 32'h00000000;
      end
    end
  end

  // Physical group 0 enable
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      en0_ff <= cif_pkg::EN0_RST;
    else if (do_wr && !vact)
      en0_ff <= req_wdata[cif_pkg::EN0_BIT];
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      ven0_ff <= cif_pkg::VEN0_RST;
    else if (do_wr && vact)
      ven0_ff <= req_wdata[cif_pkg::EN0_BIT];
  end

  // Activation event toward the distributor side
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      act_valid_ff   <= 1'b0;
      act_group_ff   <= 1'b0;
      act_virtual_ff <= 1'b0;
      act_id_ff      <= 24'h000000;
    end
    else
    begin
      act_valid_ff <= act_g0 || act_g1
                      || (do_rd && vact && hit_ack0 && vg0_pend_valid)
                      || (do_rd && vact && hit_ack1 && vg1_pend_valid);
      if (do_rd && (hit_ack0 || hit_ack1))
      begin
        act_group_ff   <= hit_ack1;
        act_virtual_ff <= vact;
        act_id_ff      <= nxt_rdata[23:0];
      end
    end
  end

  // Drop of the enable hands a waiting interrupt back for re-forwarding
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      release_ff <= 1'b0;
    else
      release_ff <= do_wr && !vact && en0_ff
                    && !req_wdata[cif_pkg::EN0_BIT] && g0_pend_valid;
  end

  // Hold is set on the same edge as the answer, so signals drop in time
  assign fiq_signal = pres_g0;
  assign irq_signal = pres_g1;

  assign rsp_valid                 = rsp_valid_ff;
  assign rsp_status                = rsp_status_ff;
  assign rsp_syndrome              = rsp_syndrome_ff;
  assign rsp_rdata                 = rsp_rdata_ff;
  assign group0_enable             = en0_ff;
  assign virtual_group0_enable_bit = ven0_ff;
  assign act_valid                 = act_valid_ff;
  assign act_group                 = act_group_ff;
  assign act_virtual               = act_virtual_ff;
  assign act_id                    = act_id_ff;
  assign g0_release                = release_ff;

endmodule : cif_ack_top

/* File: rtl/cif_pend_track.sv */
// Holds back a pending interrupt once it has been activated.
// Assumes the distributor drops or replaces the pending ID after activation.
`timescale 1ns/1ps
module cif_pend_track (
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic        pend_valid,
  input  wire logic [23:0] pend_id,
  input  wire logic        activate,
  output logic             held
);

  cif_pkg::cif_trk_t state_ff;
  cif_pkg::cif_trk_t nxt_state;
  logic [23:0]       held_id_ff;

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      cif_pkg::CIF_TRK_IDLE:
      begin
        if (activate)
          nxt_state = cif_pkg::CIF_TRK_HELD;
      end
      cif_pkg::CIF_TRK_HELD:
      begin
        // A new activation keeps the hold for the new ID
        if (!activate && (!pend_valid || pend_id != held_id_ff))
          nxt_state = cif_pkg::CIF_TRK_IDLE;
      end
      default:
        nxt_state = cif_pkg::CIF_TRK_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      state_ff <= cif_pkg::CIF_TRK_IDLE;
    else
      state_ff <= nxt_state;
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      held_id_ff <= 24'h000000;
    else if (activate)
      held_id_ff <= pend_id;
  end

  assign held = (state_ff == cif_pkg::CIF_TRK_HELD) && pend_valid
                && (pend_id == held_id_ff);

endmodule : cif_pend_track

/* File: rtl/cif_pkg.sv */
// Constants and types for the CPU interface acknowledge and group 0 enable logic.
// Assumes one clock domain shared with the processor core.
package cif_pkg;

  localparam int INTERRUPT_IDENTIFIER_W = 24;

  // Special identifiers
  localparam logic [23:0] ID_SPEC_1020 = 24'h0003FC;
  localparam logic [23:0] ID_SPEC_1021 = 24'h0003FD;
  localparam logic [23:0] ID_SPEC_1023 = 24'h0003FF;

  // System register encodings
  localparam logic [3:0] ENC_COPROC   = 4'hF;
  localparam logic [2:0] ENC_OPC1     = 3'h0;
  localparam logic [3:0] ENC_CRN      = 4'hC;
  localparam logic [3:0] ENC_CRM_ACK0 = 4'h8;
  localparam logic [3:0] ENC_CRM_ACK1 = 4'hC;
  localparam logic [3:0] ENC_CRM_EN0  = 4'hC;
  localparam logic [2:0] ENC_OPC2_ACK = 3'h0;
  localparam logic [2:0] ENC_OPC2_EN0 = 3'h6;

  localparam logic [5:0] SYND_CP15    = 6'h03;
  localparam int         EN0_BIT      = 0;
  localparam logic       EN0_RST      = 1'b0;
  localparam logic       VEN0_RST     = 1'b0;

  typedef enum logic [1:0] {
    CIF_EL0 = 2'h0,
    CIF_EL1 = 2'h1,
    CIF_EL2 = 2'h2,
    CIF_EL3 = 2'h3
  } cif_el_t;

  typedef enum logic [2:0] {
    CIF_CHK_PHYS  = 3'h0,
    CIF_CHK_VIRT  = 3'h1,
    CIF_CHK_UNDEF = 3'h2,
    CIF_CHK_THYP  = 3'h3,
    CIF_CHK_TMON  = 3'h4
  } cif_chk_t;

  typedef enum logic [1:0] {
    CIF_RSP_OK    = 2'h0,
    CIF_RSP_UNDEF = 2'h1,
    CIF_RSP_THYP  = 2'h2,
    CIF_RSP_TMON  = 2'h3
  } cif_rsp_t;

  // Reason a group 0 read sees no interrupt
  typedef enum logic [1:0] {
    CIF_WHY_NONE = 2'h0,
    CIF_WHY_SEC  = 2'h1,
    CIF_WHY_NSEC = 2'h2
  } cif_why_t;

  typedef enum logic {
    CIF_TRK_IDLE = 1'b0,
    CIF_TRK_HELD = 1'b1
  } cif_trk_t;

endpackage : cif_pkg

/* File: testbench/cif_ack_properties.sv */
// Checker for the acknowledge and group 0 enable block.
// Assumes it is bound into cif_ack_top and sees only its ports.
`timescale 1ns/1ps
module cif_ack_properties (
  input wire logic        clock,
  input wire logic        rst_b,
  input wire logic        req_valid,
  input wire logic [1:0]  req_el,
  input wire logic        hyp_enabled,
  input wire logic        hyp_cp15_trap_bit,
  input wire logic        hyp_sysreg_enable,
  input wire logic        monitor_sysreg_enable,
  input wire logic        id_width_24,
  input wire logic        g0_pend_valid,
  input wire logic [23:0] g0_pend_id,
  input wire logic        rsp_valid,
  input wire logic [1:0]  rsp_status,
  input wire logic [5:0]  rsp_syndrome,
  input wire logic [31:0] rsp_rdata,
  input wire logic        group0_enable,
  input wire logic        fiq_signal,
  input wire logic        act_valid,
  input wire logic        act_group,
  input wire logic        act_virtual,
  input wire logic [23:0] act_id,
  input wire logic        g0_release
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  a_answer_one_later: assert property (rsp_valid == $past(req_valid)) else $error("answer not one cycle after request");
  a_el0_access_undef: assert property (req_valid && req_el == 2'h0 |=> rsp_status == 2'h1)
    else $error("unprivileged access served");
  a_cp15_trap_first: assert property (req_valid && req_el == 2'h1 && hyp_enabled && hyp_cp15_trap_bit
    |=> rsp_status == 2'h2) else $error("cp15 trap not taken");
  a_hyp_sre_undef: assert property (req_valid && req_el == 2'h2 && !hyp_sysreg_enable
    |=> rsp_status == 2'h1) else $error("hyp access without enable served");
  a_mon_sre_undef: assert property (req_valid && req_el == 2'h3 && !monitor_sysreg_enable
    |=> rsp_status == 2'h1) else $error("monitor access without enable served");
  a_syndrome_code: assert property (rsp_valid
    |-> rsp_syndrome == ((rsp_status == 2'h2) ? 6'h03 : 6'h00)) else $error("bad syndrome");
  a_top_byte_zero: assert property (rsp_valid |-> rsp_rdata[31:24] == 8'h00)
    else $error("reserved top byte set");
  a_narrow_id_zero: assert property (rsp_valid && !$past(id_width_24)
    |-> rsp_rdata[23:16] == 8'h00) else $error("narrow identifier has upper bits");
  a_act_needs_read: assert property (act_valid |-> $past(req_valid) && rsp_status == 2'h0)
    else $error("activation without served access");
  a_fiq_drops_ack: assert property (act_valid && !act_group && !act_virtual && g0_pend_valid
    && g0_pend_id == act_id |-> !fiq_signal) else $error("acknowledged interrupt still signalled");
  a_release_on_clear: assert property (g0_release |-> $past(group0_enable) && !group0_enable)
    else $error("release without enable clearing");
endmodule : cif_ack_properties

bind cif_ack_top cif_ack_properties u_props (.*);

/* File: testbench/cif_core_model.sv */
// Core model issuing one system register access at a time.
// Assumes the answer comes one cycle after the request pulse.
`timescale 1ns/1ps
module cif_core_model (
  input  wire logic        clock,
  output logic             req_valid,
  output logic             req_write,
  output logic [1:0]       req_el,
  output logic [3:0]       req_coproc,
  output logic [2:0]       req_opc1,
  output logic [3:0]       req_crn,
  output logic [3:0]       req_crm,
  output logic [2:0]       req_opc2,
  output logic [31:0]      req_wdata,
  input  wire logic        rsp_valid,
  input  wire logic [1:0]  rsp_status,
  input  wire logic [31:0] rsp_rdata
);
  logic [1:0]  got_status;
  logic [31:0] got_rdata;
  logic        got_valid;
  initial
  begin
    req_valid  = 1'b0;
    req_write  = 1'b0;
    req_el     = 2'h3;
    req_coproc = 4'hF;
    req_opc1   = 3'h0;
    req_crn    = 4'hC;
    req_crm    = 4'h0;
    req_opc2   = 3'h0;
    req_wdata  = 32'h0;
  end
  // One pulse; the answer is read once it has settled after the taking edge
  task automatic access(input logic [1:0] el, input logic wr, input logic [3:0] crm,
                        input logic [2:0] op2, input logic [31:0] wd);
    @(posedge clock);
    #1;
    req_valid = 1'b1;
    req_write = wr;
    req_el    = el;
    req_crm   = crm;
    req_opc2  = op2;
    req_wdata = wd;
    @(posedge clock);
    #1;
    req_valid  = 1'b0;
    req_wdata  = ~wd; // Held data stops looking valid
    got_valid  = rsp_valid;
    got_status = rsp_status;
    got_rdata  = rsp_rdata;
  endtask : access
endmodule : cif_core_model

/* File: testbench/tb_top.sv */
// Self-checking bench for the acknowledge and group 0 enable block.
// Assumes the core model and the checker sit beside the design.
`timescale 1ns/1ps
module tb_top;
  logic        clock, rst_b, req_monitor_mode, hyp_enabled, monitor_present;
  logic        hyp_cp15_trap_bit, os_sysreg_enable, hyp_sysreg_enable, monitor_sysreg_enable;
  logic        trap_all_group0, trap_all_group1, hyp_fiq_route, hyp_irq_route;
  logic        monitor_fiq_route, monitor_irq_route, id_width_24, group1_enable;
  logic        g0_pend_valid, g0_pend_prio_ok, g0_pend_ack_ok, g1_pend_valid;
  logic        g1_pend_prio_ok, g1_pend_ack_ok, vg0_pend_valid, vg1_pend_valid;
  logic        req_valid, req_write, rsp_valid, group0_enable, virtual_group0_enable_bit;
  logic        fiq_signal, irq_signal, act_valid, act_group, act_virtual, g0_release;
  logic [1:0]  g0_why, req_el, rsp_status;
  logic [23:0] g0_pend_id, g1_pend_id, vg0_pend_id, vg1_pend_id, act_id;
  logic [3:0]  req_coproc, req_crn, req_crm;
  logic [2:0]  req_opc1, req_opc2;
  logic [31:0] req_wdata, rsp_rdata;
  logic [5:0]  rsp_syndrome;
  int          miscompares, samples_checked, cycles;

  cif_ack_top    dut (.*);
  cif_core_model core (.*);

  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_word

  task automatic chk_bit(input string what, input logic exp, input logic got);
    chk_word(what, {31'h0, exp}, {31'h0, got});
  endtask : chk_bit

  task automatic quiet();
    {req_monitor_mode, hyp_enabled, hyp_cp15_trap_bit, trap_all_group0} = 4'h0;
    {trap_all_group1, hyp_fiq_route, hyp_irq_route, monitor_fiq_route} = 4'h0;
    {monitor_irq_route, g0_pend_valid, g1_pend_valid, vg0_pend_valid, vg1_pend_valid} = 5'h0;
    {monitor_present, os_sysreg_enable, hyp_sysreg_enable, monitor_sysreg_enable} = 4'hF;
    {id_width_24, group1_enable, g0_pend_prio_ok, g0_pend_ack_ok} = 4'hF;
    {g1_pend_prio_ok, g1_pend_ack_ok} = 2'h3;
    g0_why = 2'h0;
    {g0_pend_id, g1_pend_id, vg0_pend_id, vg1_pend_id} = 96'h0;
  endtask : quiet

  task automatic rd(input logic [1:0] el, input logic [3:0] crm, input logic [2:0] op2);
    core.access(el, 1'b0, crm, op2, 32'h0);
    chk_bit("answer valid", 1'b1, core.got_valid);
  endtask : rd

  task automatic t_enable();
    rd(2'h3, 4'hC, 3'h6);
    chk_word("enable at reset", 32'h0, core.got_rdata);
    core.access(2'h3, 1'b1, 4'hC, 3'h6, 32'hFFFFFFFF);
    chk_bit("enable set", 1'b1, group0_enable);
    rd(2'h3, 4'hC, 3'h6);
    chk_word("enable readback", 32'h1, core.got_rdata);
    $display("t_enable done");
  endtask : t_enable

  task automatic t_ack0();
    quiet();
    g0_pend_valid = 1'b1;
    g0_pend_id    = 24'h000123;
    rd(2'h1, 4'h8, 3'h0);
    chk_word("ack0 id", 32'h123, core.got_rdata);
    chk_bit("ack0 act", 1'b1, act_valid);
    chk_word("ack0 act id", 32'h123, {8'h00, act_id});
    chk_bit("fiq after ack", 1'b0, fiq_signal);
    rd(2'h1, 4'h8, 3'h0);
    chk_word("ack0 held", 32'h3FF, core.got_rdata);
    g0_pend_valid = 1'b0;
    for (int w = 0; w < 3; w++)
    begin
      g0_why = w[1:0];
      rd(2'h1, 4'h8, 3'h0);
      chk_word("ack0 special", (w == 0) ? 32'h3FF : 32'h3FB + w, core.got_rdata);
    end
    $display("t_ack0 done");
  endtask : t_ack0

  task automatic t_ack1();
    quiet();
    {g1_pend_valid, id_width_24, g0_why} = 4'h9;
    g1_pend_id = 24'hABCDEF;
    rd(2'h1, 4'hC, 3'h0);
    chk_word("ack1 narrow id", 32'h0000CDEF, core.got_rdata);
    chk_bit("ack1 group", 1'b1, act_group);
    chk_bit("irq after ack", 1'b0, irq_signal);
    g1_pend_id     = 24'h000456;
    g1_pend_ack_ok = 1'b0;
    rd(2'h1, 4'hC, 3'h0);
    chk_word("ack1 special", 32'h3FF, core.got_rdata);
    $display("t_ack1 done");
  endtask : t_ack1

  task automatic t_checks();
    logic [1:0] el, exp;
    logic [3:0] crm;
    logic       wr;
    for (int c = 0; c < 14; c++)
    begin
      quiet();
      {el, crm, wr, exp} = {2'h1, 4'h8, 1'b0, 2'h0};
      case (c)
        0: {el, exp} = {2'h0, 2'h1};
        1: {hyp_enabled, hyp_cp15_trap_bit, os_sysreg_enable, exp} = 5'b11010;
        2: {os_sysreg_enable, exp} = 3'b001;
        3: {hyp_enabled, trap_all_group0, exp} = 4'b1110;
        4: {monitor_fiq_route, exp} = 3'b111;
        5: {monitor_fiq_route, req_monitor_mode} = 2'b11;
        6: {el, hyp_sysreg_enable, exp} = 5'b10001;
        7: {el, monitor_fiq_route, exp} = 5'b10111;
        8: {el, monitor_sysreg_enable, exp} = 5'b11001;
        9: {crm, exp} = {4'h9, 2'h1};
        10: {wr, exp} = 3'b101;
        11: {crm, hyp_enabled, trap_all_group1, exp} = {4'hC, 4'b1110};
        12: {crm, monitor_irq_route, exp} = {4'hC, 3'b111};
        default: {hyp_enabled, trap_all_group1} = 2'b11;
      endcase
      core.access(el, wr, crm, 3'h0, 32'h0);
      chk_word("status", {30'h0, exp}, {30'h0, core.got_status});
      chk_bit("refused no act", 1'b0, act_valid);
    end
    $display("t_checks done");
  endtask : t_checks

  task automatic t_virtual();
    quiet();
    {hyp_enabled, hyp_fiq_route, hyp_irq_route, vg0_pend_valid, vg1_pend_valid} = 5'h1F;
    {vg0_pend_id, vg1_pend_id} = {24'h000042, 24'h000077};
    rd(2'h1, 4'h8, 3'h0);
    chk_word("virtual ack0", 32'h42, core.got_rdata);
    chk_bit("virtual act", 1'b1, act_virtual);
    rd(2'h1, 4'hC, 3'h0);
    chk_word("virtual ack1", 32'h77, core.got_rdata);
    core.access(2'h1, 1'b1, 4'hC, 3'h6, 32'h1);
    chk_bit("virtual enable", 1'b1, virtual_group0_enable_bit);
    chk_bit("physical kept", 1'b0, group0_enable);
    $display("t_virtual done");
  endtask : t_virtual

  task automatic t_release();
    quiet();
    core.access(2'h3, 1'b1, 4'hC, 3'h6, 32'h1);
    g0_pend_valid = 1'b1;
    g0_pend_id    = 24'h000321;
    core.access(2'h3, 1'b1, 4'hC, 3'h6, 32'h0);
    chk_bit("release", 1'b1, g0_release);
    chk_bit("fiq off", 1'b0, fiq_signal);
    $display("t_release done");
  endtask : t_release

  task automatic finish_test();
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : finish_test

  // Ceiling well above the 63 or so cycles the tests take
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      miscompares++;
      finish_test();
    end
  end

  initial
  begin
    {miscompares, samples_checked, cycles} = '0;
    rst_b = 1'b0;
    quiet();
    repeat (5) @(posedge clock);
    #1;
    rst_b = 1'b1;
    t_enable();
    t_ack0();
    t_ack1();
    t_checks();
    t_release();
    t_virtual();
    finish_test();
  end
endmodule : tb_top
